// ### io_latch_pkg.sv
// shared constants, opcodes and carriers for the io/latch instruction unit
package io_latch_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_INSTR = 12'h000;
  localparam logic [11:0] ADDR_ACC = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_PORT_CFG = 12'h00c;
  localparam logic [11:0] ADDR_PINS = 12'h010;
  localparam logic [11:0] LATCH_BASE = 12'h100;
  localparam logic [11:0] RAM_BASE = 12'h200;
  localparam logic [6:0] WR_BASE = 7'h70;
  localparam int RAM_WORDS = 128;
  localparam int LATCH_WORDS = 32;
  localparam int SEG_PINS = 12;
  localparam int PULL_BIT = 4;
  localparam int HALT_BIT = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] PORT_DIR_RST = 4'h0;
  localparam logic [7:0] SCAN_CFG_RST = 8'h20;

  typedef enum logic [4:0] {
    OP_DEC_RY = 5'h00, OP_DEC_HL = 5'h01, OP_BLANK_RY = 5'h02, OP_BLANK_HL = 5'h03,
    OP_PAIR_RY = 5'h04, OP_PAIR_HL = 5'h05, OP_TABLE = 5'h06, OP_IDX_HIGH = 5'h07,
    OP_IDX_LOW = 5'h08, OP_A_SETUP = 5'h09, OP_A_WRITE = 5'h0a, OP_A_SPECIAL = 5'h0b,
    OP_A_READ = 5'h0c, OP_B_SETUP = 5'h0d, OP_B_WRITE = 5'h0e, OP_B_READ = 5'h0f,
    OP_C_SETUP = 5'h10, OP_C_WRITE = 5'h11, OP_C_READ = 5'h12, OP_SCAN_SETUP = 5'h13
  } op_t;

  // instruction word as written to the instruction register
  typedef struct packed {
    logic [2:0] rsv0;
    logic [4:0] op;
    logic [2:0] rsv1;
    logic [4:0] latch_sel;
    logic [6:0] rsv2;
    logic dbit;
    logic [7:0] imm;
  } instr_t;

  // one port's setup state and output data
  typedef struct packed {
    logic pull_en;
    logic [3:0] dir;
    logic [3:0] data;
  } port_state_t;
endpackage

// ### io_port_latch_instr_unit.sv
// io port, index pointer and display latch instruction unit with axi4-lite access
`timescale 1ns/1ps
module io_port_latch_instr_unit #(
  parameter int LATCH_W = 8
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [7:0] table_rom_addr_o,
  input wire logic [7:0] table_rom_data_i,
  input wire logic [4:0] latch_rd_sel_i,
  output logic [LATCH_W-1:0] latch_rd_data_o,
  input wire logic [3:0] port_a_i,
  output logic [3:0] port_a_o,
  output logic [3:0] port_a_oe_o,
  output logic [3:0] port_a_pull_low_o,
  input wire logic [3:0] port_b_i,
  output logic [3:0] port_b_o,
  output logic [3:0] port_b_oe_o,
  output logic [3:0] port_b_pull_low_o,
  input wire logic [3:0] port_c_i,
  output logic [3:0] port_c_o,
  output logic [3:0] port_c_oe_o,
  output logic [3:0] port_c_pull_low_o,
  output logic [3:0] port_c_hold_low_o,
  input wire logic scan_interval_i,
  input wire logic display_active_high_i,
  output logic [11:0] segment_pins_one_to_twelve_o,
  output logic [11:0] segment_pins_one_to_twelve_oe_o,
  output logic halt_release_by_cycle_o
);
  if (LATCH_W != 8) begin : g_latch_w_check
    $error("latch width must be 8");
  end

  logic [3:0] ram_q [io_latch_pkg::RAM_WORDS];
  logic [LATCH_W-1:0] latch_q [io_latch_pkg::LATCH_WORDS];
  logic [7:0] index_pointer_q;
  logic [3:0] accumulator_q;
  io_latch_pkg::port_state_t pa_q, pb_q, pc_q;
  logic [7:0] scan_cfg_q;
  logic [11:0] scan_sel_q;
  logic pulse_q;
  logic awv_q, wv_q, bvalid_q, rvalid_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;

  // seven-segment style data decoder, bit 7 unused
  function automatic logic [7:0] seg_decode(input logic [3:0] v);
    unique case (v)
      4'h0: seg_decode = 8'h3f; 4'h1: seg_decode = 8'h06;
      4'h2: seg_decode = 8'h5b; 4'h3: seg_decode = 8'h4f;
      4'h4: seg_decode = 8'h66; 4'h5: seg_decode = 8'h6d;
      4'h6: seg_decode = 8'h7d; 4'h7: seg_decode = 8'h07;
      4'h8: seg_decode = 8'h7f; 4'h9: seg_decode = 8'h6f;
      4'ha: seg_decode = 8'h77; 4'hb: seg_decode = 8'h7c;
      4'hc: seg_decode = 8'h39; 4'hd: seg_decode = 8'h5e;
      4'he: seg_decode = 8'h79; 4'hf: seg_decode = 8'h71;
    endcase
  endfunction

  // scan pin selection from the key scan setting
  function automatic logic [11:0] scan_decode(input logic [7:0] x);
    logic [11:0] s;
    s = 12'h000;
    if (!x[7]) begin
      if (x[5]) s = 12'h000;
      else if (x[4]) s = 12'hfff;
      else if (x[3:0] < 4'hc) s = 12'(12'h001 << x[3:0]);
    end else if (!x[5]) begin
      s = x[3] ? 12'hf00 : 12'h0ff;
    end else if (!x[4]) begin
      if (x[3:2] != 2'h3) s = 12'(12'h00f << {x[3:2], 2'h0});
    end else if (x[3:1] < 3'h6) begin
      s = 12'(12'h003 << {x[3:1], 1'h0});
    end
    scan_decode = s;
  endfunction

  // write path: address and data latched in either order
  io_latch_pkg::instr_t instr;
  logic wr_go, wr_instr, wr_acc, wr_ram, exec;
  assign wr_go = awv_q & wv_q & ~bvalid_q;
  assign wr_instr = awaddr_q == io_latch_pkg::ADDR_INSTR;
  assign wr_acc = awaddr_q == io_latch_pkg::ADDR_ACC;
  assign wr_ram = awaddr_q[11:9] == io_latch_pkg::RAM_BASE[11:9] && awaddr_q[1:0] == 2'h0;
  assign instr = io_latch_pkg::instr_t'(wdata_q);
  assign exec = wr_go & wr_instr & (wstrb_q == 4'hf);
  assign s_axi_awready = ~awv_q;
  assign s_axi_wready = ~wv_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      awv_q <= 1'b0;
      wv_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= io_latch_pkg::RESP_OKAY;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && !awv_q) begin
        awv_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wv_q) begin
        wv_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        awv_q <= 1'b0;
        wv_q <= 1'b0;
        bvalid_q <= 1'b1;
        // instruction needs a whole word; a partial one is refused
        bresp_q <= (exec || wr_acc || wr_ram) ? io_latch_pkg::RESP_OKAY
                                               : io_latch_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // operand fetch for the instruction being executed
  logic [6:0] rx_addr, ry_addr;
  logic [3:0] rx_word, ry_word, hl_word, src_word, pin_word;
  logic from_hl;
  io_latch_pkg::op_t op;
  assign op = io_latch_pkg::op_t'(instr.op);
  assign rx_addr = instr.imm[6:0];
  assign ry_addr = 7'(io_latch_pkg::WR_BASE + {3'h0, instr.imm[3:0]});
  assign rx_word = ram_q[rx_addr];
  assign ry_word = ram_q[ry_addr];
  assign hl_word = ram_q[index_pointer_q[6:0]];
  assign from_hl = op inside {io_latch_pkg::OP_DEC_HL, io_latch_pkg::OP_BLANK_HL,
                              io_latch_pkg::OP_PAIR_HL};
  assign src_word = from_hl ? hl_word : ry_word;
  assign table_rom_addr_o = index_pointer_q;
  assign pin_word = (op == io_latch_pkg::OP_A_READ) ? port_a_i :
                    (op == io_latch_pkg::OP_B_READ) ? port_b_i : port_c_i;

  // display latch loads; the 5-bit selector covers 00H..1FH only
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < io_latch_pkg::LATCH_WORDS; i++) latch_q[i] <= '0;
    end else if (exec) begin
      unique case (op)
        io_latch_pkg::OP_DEC_RY, io_latch_pkg::OP_DEC_HL:
          latch_q[instr.latch_sel] <= seg_decode(src_word);
        io_latch_pkg::OP_BLANK_RY, io_latch_pkg::OP_BLANK_HL:
          latch_q[instr.latch_sel] <= (src_word == 4'h0) ? 8'h00 : seg_decode(src_word);
        io_latch_pkg::OP_PAIR_RY, io_latch_pkg::OP_PAIR_HL:
          latch_q[instr.latch_sel] <= {accumulator_q, src_word};
        io_latch_pkg::OP_TABLE:
          latch_q[instr.latch_sel] <= table_rom_data_i;
        default: ;
      endcase
    end
  end

  // index pointer nibble loads
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      index_pointer_q <= 8'h00;
    end else if (exec && op == io_latch_pkg::OP_IDX_HIGH) begin
      index_pointer_q[7:4] <= rx_word;
    end else if (exec && op == io_latch_pkg::OP_IDX_LOW) begin
      index_pointer_q[3:0] <= rx_word;
    end
  end

  // memory contents are not reset; software must fill them first
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      accumulator_q <= 4'h0;
    end else if (exec && op inside {io_latch_pkg::OP_A_READ, io_latch_pkg::OP_B_READ,
                                    io_latch_pkg::OP_C_READ}) begin
      accumulator_q <= pin_word;
      ram_q[rx_addr] <= pin_word;
    end else if (wr_go && wr_acc && wstrb_q[0]) begin
      accumulator_q <= wdata_q[3:0];
    end else if (wr_go && wr_ram && wstrb_q[0]) begin
      ram_q[awaddr_q[8:2]] <= wdata_q[3:0];
    end
  end

  // port setup and output data
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      pa_q <= '{1'b0, io_latch_pkg::PORT_DIR_RST, 4'h0};
      pb_q <= '{1'b0, io_latch_pkg::PORT_DIR_RST, 4'h0};
      pc_q <= '{1'b0, io_latch_pkg::PORT_DIR_RST, 4'h0};
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= exec && op == io_latch_pkg::OP_A_SPECIAL;
      if (exec) begin
        unique case (op)
          io_latch_pkg::OP_A_SETUP: begin
            pa_q.dir <= instr.imm[3:0];
            pa_q.pull_en <= instr.imm[io_latch_pkg::PULL_BIT];
          end
          io_latch_pkg::OP_A_WRITE: pa_q.data <= rx_word;
          io_latch_pkg::OP_A_SPECIAL: pa_q.data <= {1'b0, instr.dbit, rx_word[1:0]};
          io_latch_pkg::OP_B_SETUP: begin
            pb_q.dir <= instr.imm[3:0];
            pb_q.pull_en <= instr.imm[io_latch_pkg::PULL_BIT];
          end
          io_latch_pkg::OP_B_WRITE: pb_q.data <= rx_word;
          io_latch_pkg::OP_C_SETUP: begin
            pc_q.dir <= instr.imm[3:0];
            pc_q.pull_en <= instr.imm[io_latch_pkg::PULL_BIT];
          end
          io_latch_pkg::OP_C_WRITE: pc_q.data <= rx_word;
          default: ;
        endcase
      end
    end
  end

  // pin drive; pulls only reach input pins
  assign port_a_o = {pa_q.data[3] | pulse_q, pa_q.data[2:0]};
  assign port_a_oe_o = pa_q.dir;
  assign port_b_o = pb_q.data;
  assign port_b_oe_o = pb_q.dir;
  assign port_c_o = pc_q.data;
  assign port_c_oe_o = pc_q.dir;
  assign port_a_pull_low_o = {4{pa_q.pull_en}} & ~pa_q.dir;
  assign port_b_pull_low_o = {4{pb_q.pull_en}} & ~pb_q.dir;
  assign port_c_pull_low_o = {4{pc_q.pull_en}} & ~pc_q.dir;
  assign port_c_hold_low_o = {4{~pc_q.pull_en}} & ~pc_q.dir;

  // key scan setting; decoded once so the pins see a flop
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      scan_cfg_q <= io_latch_pkg::SCAN_CFG_RST;
      scan_sel_q <= 12'h000;
    end else if (exec && op == io_latch_pkg::OP_SCAN_SETUP) begin
      scan_cfg_q <= instr.imm;
      scan_sel_q <= scan_decode(instr.imm);
    end
  end
  assign halt_release_by_cycle_o = scan_cfg_q[io_latch_pkg::HALT_BIT];
  assign segment_pins_one_to_twelve_o = {12{display_active_high_i}};
  assign segment_pins_one_to_twelve_oe_o = scan_sel_q & {12{scan_interval_i}};

  // read path
  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr[11:9] == io_latch_pkg::RAM_BASE[11:9])
      rd_mux = {28'h0, ram_q[s_axi_araddr[8:2]]};
    else if (s_axi_araddr[11:7] == io_latch_pkg::LATCH_BASE[11:7])
      rd_mux = {24'h0, latch_q[s_axi_araddr[6:2]]};
    else if (s_axi_araddr == io_latch_pkg::ADDR_ACC)
      rd_mux = {28'h0, accumulator_q};
    else if (s_axi_araddr == io_latch_pkg::ADDR_STATUS)
      rd_mux = {16'h0, scan_cfg_q, index_pointer_q[7:4], index_pointer_q[3:0]};
    else if (s_axi_araddr == io_latch_pkg::ADDR_PORT_CFG)
      rd_mux = {11'h0, pc_q.pull_en, pc_q.dir, 3'h0, pb_q.pull_en, pb_q.dir,
                3'h0, pa_q.pull_en, pa_q.dir};
    else if (s_axi_araddr == io_latch_pkg::ADDR_PINS)
      rd_mux = {20'h0, port_c_i, port_b_i, port_a_i};
    else if (s_axi_araddr != io_latch_pkg::ADDR_INSTR)
      rd_ok = 1'b0;
  end
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= io_latch_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_ok ? rd_mux : 32'h0000_0000;
      rresp_q <= rd_ok ? io_latch_pkg::RESP_OKAY : io_latch_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // latch read port for the display driver
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) latch_rd_data_o <= '0;
    else latch_rd_data_o <= latch_q[latch_rd_sel_i];
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  property p_decoded_ry;
    exec && op == io_latch_pkg::OP_DEC_RY |=>
      latch_q[$past(instr.latch_sel)] ==
        seg_decode($past(ram_q[io_latch_pkg::WR_BASE | {3'h0, instr.imm[3:0]}]));
  endproperty
  a_decoded_ry: assert property (p_decoded_ry) else $error("decoded load wrong");
  property p_blank;
    exec && op == io_latch_pkg::OP_BLANK_HL && hl_word == 4'h0 |=>
      latch_q[$past(instr.latch_sel)] == 8'h00;
  endproperty
  a_blank: assert property (p_blank) else $error("blanking not zero");
  property p_pair;
    exec && op == io_latch_pkg::OP_PAIR_RY |=>
      latch_q[$past(instr.latch_sel)] == {$past(accumulator_q), $past(ry_word)};
  endproperty
  a_pair: assert property (p_pair) else $error("pair load wrong");
  property p_table;
    exec && op == io_latch_pkg::OP_TABLE |=>
      latch_q[$past(instr.latch_sel)] == $past(table_rom_data_i);
  endproperty
  a_table: assert property (p_table) else $error("table load wrong");
  property p_idx_high;
    exec && op == io_latch_pkg::OP_IDX_HIGH |=>
      index_pointer_q == {$past(rx_word), $past(index_pointer_q[3:0])};
  endproperty
  a_idx_high: assert property (p_idx_high) else $error("high nibble load wrong");
  property p_pull_inputs;
    (port_a_pull_low_o & port_a_oe_o) == 4'h0 && (port_c_pull_low_o & port_c_oe_o) == 4'h0;
  endproperty
  a_pull_inputs: assert property (p_pull_inputs) else $error("pull on output pin");
  property p_pulse;
    exec && op == io_latch_pkg::OP_A_SPECIAL |=> port_a_o[3] ##1 !port_a_o[3];
  endproperty
  a_pulse: assert property (p_pulse) else $error("pin 4 pulse wrong");
  property p_read_a;
    exec && op == io_latch_pkg::OP_A_READ |=>
      accumulator_q == $past(port_a_i) && ram_q[$past(rx_addr)] == $past(port_a_i);
  endproperty
  a_read_a: assert property (p_read_a) else $error("port a read wrong");
  property p_setup_a;
    exec && op == io_latch_pkg::OP_A_SETUP |=>
      pa_q.pull_en == $past(instr.imm[4]) && port_a_oe_o == $past(instr.imm[3:0]);
  endproperty
  a_setup_a: assert property (p_setup_a) else $error("port a setup wrong");
  property p_halt;
    exec && op == io_latch_pkg::OP_SCAN_SETUP |=> halt_release_by_cycle_o == $past(instr.imm[6]);
  endproperty
  a_halt: assert property (p_halt) else $error("halt source wrong");

  c_table: cover property (exec && op == io_latch_pkg::OP_TABLE);
  c_read_b: cover property (exec && op == io_latch_pkg::OP_B_READ);
  c_scan: cover property (scan_interval_i && segment_pins_one_to_twelve_oe_o != 12'h000);
endmodule

// ### pin_world_model.sv
// far-side model: port pins with outside drivers, pull and hold devices, and the table rom
`timescale 1ns/1ps
module pin_world_model (
  input wire logic clock_i,
  input wire logic [11:0] pin_out_i,
  input wire logic [11:0] pin_oe_i,
  input wire logic [11:0] pin_low_i,
  input wire logic [11:0] ext_en_i,
  input wire logic [11:0] ext_val_i,
  output logic [11:0] pin_level_o,
  input wire logic [7:0] rom_addr_i,
  output logic [7:0] rom_data_o
);
  logic [11:0] last_q = 12'h000;
  // device driver wins, then the outside driver, then pull-low or hold, else floating
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      if (pin_oe_i[i]) begin
        pin_level_o[i] = pin_out_i[i];
      end else if (ext_en_i[i]) begin
        pin_level_o[i] = ext_val_i[i];
      end else if (pin_low_i[i]) begin
        pin_level_o[i] = 1'b0;
      end else begin
        pin_level_o[i] = ~last_q[i]; // floating pin must never look like a held value
      end
    end
  end
  // remember the last level so a floating pin keeps toggling
  always_ff @(posedge clock_i) begin
    last_q <= pin_level_o;
  end
  // rom words are arbitrary; a scrambled address keeps every word distinct
  assign rom_data_o = rom_addr_i ^ 8'ha5;
endmodule

// ### io_port_latch_instr_unit_test.sv
// self-checking bench for the io port, index pointer and display latch unit
`timescale 1ns/1ps
module io_port_latch_instr_unit_test;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, halt_cycle;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [7:0] rom_addr, rom_data, latch_data;
  logic [4:0] latch_sel = 5'h00;
  logic scan_on = 1'b0, disp_high = 1'b1;
  logic [11:0] pin_out, pin_oe, pin_pull, pin_lvl, seg, seg_oe;
  logic [11:0] ext_en = 12'h000, ext_val = 12'ha96;
  logic [3:0] hold_c;
  int miscompares = 0, cmp_count = 0, cycles = 0, pulses = 0;
  logic [7:0] seg7 [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h07,
    8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};
  logic [4:0] op_su [3] = '{io_latch_pkg::OP_A_SETUP, io_latch_pkg::OP_B_SETUP,
    io_latch_pkg::OP_C_SETUP};
  logic [4:0] op_wr [3] = '{io_latch_pkg::OP_A_WRITE, io_latch_pkg::OP_B_WRITE,
    io_latch_pkg::OP_C_WRITE};
  logic [4:0] op_rd [3] = '{io_latch_pkg::OP_A_READ, io_latch_pkg::OP_B_READ,
    io_latch_pkg::OP_C_READ};
  logic [7:0] scan_imm [9] = '{8'h00, 8'h0b, 8'h10, 8'h20, 8'h80, 8'hc8, 8'ha4, 8'hb2, 8'h45};
  logic [11:0] scan_exp [9] = '{12'h001, 12'h800, 12'hfff, 12'h000, 12'h0ff, 12'hf00,
    12'h0f0, 12'h00c, 12'h020};

  io_port_latch_instr_unit #(.LATCH_W(8)) io_port_latch_instr_unit_i (
    .clock_i(clock_i), .reset_n_i(reset_n_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .table_rom_addr_o(rom_addr), .table_rom_data_i(rom_data),
    .latch_rd_sel_i(latch_sel), .latch_rd_data_o(latch_data),
    .port_a_i(pin_lvl[3:0]), .port_a_o(pin_out[3:0]), .port_a_oe_o(pin_oe[3:0]),
    .port_a_pull_low_o(pin_pull[3:0]),
    .port_b_i(pin_lvl[7:4]), .port_b_o(pin_out[7:4]), .port_b_oe_o(pin_oe[7:4]),
    .port_b_pull_low_o(pin_pull[7:4]),
    .port_c_i(pin_lvl[11:8]), .port_c_o(pin_out[11:8]), .port_c_oe_o(pin_oe[11:8]),
    .port_c_pull_low_o(pin_pull[11:8]), .port_c_hold_low_o(hold_c),
    .scan_interval_i(scan_on), .display_active_high_i(disp_high),
    .segment_pins_one_to_twelve_o(seg), .segment_pins_one_to_twelve_oe_o(seg_oe),
    .halt_release_by_cycle_o(halt_cycle)
  );

  pin_world_model pin_world_model_i (
    .clock_i(clock_i), .pin_out_i(pin_out), .pin_oe_i(pin_oe),
    .pin_low_i(pin_pull | {hold_c, 8'h00}), .ext_en_i(ext_en), .ext_val_i(ext_val),
    .pin_level_o(pin_lvl), .rom_addr_i(rom_addr), .rom_data_o(rom_data)
  );

  initial begin
    forever #5 clock_i = ~clock_i;
  end

  // watchdog, well above the few hundred cycles the sequence needs
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  // count high cycles on the fourth port a pin
  always @(posedge clock_i) begin
    if (pin_out[3] === 1'b1) pulses++;
  end

  task automatic summarize();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // handshakes are judged at the falling edge, acted on just after the rising one
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_hs, w_hs, b_hs;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_hs = 1'b0;
    while (!b_hs) begin
      @(negedge clock_i);
      aw_hs = awvalid & awready;
      w_hs = wvalid & wready;
      b_hs = bvalid;
      resp = bresp;
      @(posedge clock_i);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
  endtask

  task automatic rdx(input logic [11:0] a);
    logic ar_hs, r_hs;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs) begin
      @(negedge clock_i);
      ar_hs = arvalid & arready;
      r_hs = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge clock_i);
      if (ar_hs) arvalid <= 1'b0;
    end
  endtask

  task automatic ins(input logic [4:0] op, input logic [4:0] sel, input logic d,
                     input logic [7:0] imm);
    wr(io_latch_pkg::ADDR_INSTR, {3'h0, op, 3'h0, sel, 7'h00, d, imm}, 4'hf);
  endtask

  task automatic ram(input logic [6:0] n, input logic [3:0] v);
    wr(io_latch_pkg::RAM_BASE + {3'h0, n, 2'b00}, {28'h0000000, v}, 4'hf);
  endtask

  // latch seen both over the bus and on the side read port
  task automatic chk_latch(input logic [4:0] n, input logic [7:0] exp);
    rdx(io_latch_pkg::LATCH_BASE + {5'h00, n, 2'b00});
    chk("latch over bus", rd, {24'h000000, exp});
    latch_sel <= n;
    @(posedge clock_i);
    @(negedge clock_i);
    chk("latch side port", {24'h000000, latch_data}, {24'h000000, exp});
    @(posedge clock_i);
  endtask

  initial begin
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(posedge clock_i);
    rdx(io_latch_pkg::ADDR_STATUS);
    chk("status after reset", rd, 32'h00002000);
    // working registers are seeded before any use
    for (int n = 0; n < 16; n++) begin
      ram(7'h70 + 7'(n), 4'(n));
    end
    for (int n = 0; n < 16; n++) begin
      ins(io_latch_pkg::OP_DEC_RY, 5'(n), 1'b0, 8'(n));
      chk_latch(5'(n), seg7[n]);
      ins(io_latch_pkg::OP_BLANK_RY, 5'(n + 16), 1'b0, 8'(n));
      chk_latch(5'(n + 16), (n == 0) ? 8'h00 : seg7[n]);
    end
    rdx(12'h180);
    chk("latch past range", {30'h0, resp}, {30'h0, io_latch_pkg::RESP_SLVERR});
    ram(7'h10, 4'h1);
    ram(7'h11, 4'hc);
    ins(io_latch_pkg::OP_IDX_HIGH, 5'h00, 1'b0, 8'h10);
    ins(io_latch_pkg::OP_IDX_LOW, 5'h00, 1'b0, 8'h11);
    rdx(io_latch_pkg::ADDR_STATUS);
    chk("index pointer", 32'(rd[7:0]), 32'h1c);
    chk("table address", 32'(rom_addr), 32'h1c);
    ram(7'h1c, 4'h5);
    ins(io_latch_pkg::OP_DEC_HL, 5'h02, 1'b0, 8'h00);
    chk_latch(5'h02, 8'h6d);
    ram(7'h1c, 4'h0);
    ins(io_latch_pkg::OP_BLANK_HL, 5'h03, 1'b0, 8'h00);
    chk_latch(5'h03, 8'h00);
    wr(io_latch_pkg::ADDR_ACC, 32'h0000000a, 4'hf);
    ram(7'h1c, 4'h7);
    ins(io_latch_pkg::OP_PAIR_HL, 5'h04, 1'b0, 8'h00);
    chk_latch(5'h04, 8'ha7);
    ins(io_latch_pkg::OP_PAIR_RY, 5'h05, 1'b0, 8'h03);
    chk_latch(5'h05, 8'ha3);
    ins(io_latch_pkg::OP_TABLE, 5'h06, 1'b0, 8'h00);
    chk_latch(5'h06, 8'h1c ^ 8'ha5);
    ram(7'h12, 4'hf);
    ins(io_latch_pkg::OP_IDX_HIGH, 5'h00, 1'b0, 8'h12);
    ins(io_latch_pkg::OP_TABLE, 5'h07, 1'b0, 8'h00);
    chk_latch(5'h07, 8'hfc ^ 8'ha5);
    // each port: setup variants, write, read with outside drive, read pulled low
    for (int p = 0; p < 3; p++) begin
      ins(op_su[p], 5'h00, 1'b0, 8'h15);
      rdx(io_latch_pkg::ADDR_PORT_CFG);
      chk("setup field", 32'(rd[8*p +: 5]), 32'h15);
      chk("direction", 32'(pin_oe[4*p +: 4]), 32'h5);
      chk("pull on inputs", 32'(pin_pull[4*p +: 4]), 32'ha);
      if (p == 2) chk("hold off", 32'(hold_c), 32'h0);
      ins(op_su[p], 5'h00, 1'b0, 8'h03);
      chk("pull off", 32'(pin_pull[4*p +: 4]), 32'h0);
      if (p == 2) chk("hold on inputs", 32'(hold_c), 32'hc);
      ins(op_su[p], 5'h00, 1'b0, 8'h1f);
      chk("no pull on outputs", 32'(pin_pull[4*p +: 4]), 32'h0);
      ram(7'h30 + 7'(p), 4'h9 + 4'(p));
      ins(op_wr[p], 5'h00, 1'b0, 8'h30 + 8'(p));
      chk("port drive", 32'(pin_out[4*p +: 4]), 32'h9 + 32'(p));
      ins(op_su[p], 5'h00, 1'b0, 8'h10);
      ext_en <= 12'hfff;
      ins(op_rd[p], 5'h00, 1'b0, 8'h40 + 8'(p));
      rdx(io_latch_pkg::ADDR_ACC);
      chk("acc from pins", 32'(rd[3:0]), 32'(ext_val[4*p +: 4]));
      rdx(io_latch_pkg::RAM_BASE + 12'h100 + 12'(4 * p));
      chk("ram from pins", 32'(rd[3:0]), 32'(ext_val[4*p +: 4]));
      ext_en <= 12'h000;
      ins(op_rd[p], 5'h00, 1'b0, 8'h40 + 8'(p));
      rdx(io_latch_pkg::ADDR_ACC);
      chk("pulled pins", 32'(rd[3:0]), 32'h0);
    end
    ins(io_latch_pkg::OP_A_SETUP, 5'h00, 1'b0, 8'h0f);
    ram(7'h21, 4'h2);
    // clear pin four first so only the pulse is counted
    ins(io_latch_pkg::OP_A_WRITE, 5'h00, 1'b0, 8'h21);
    chk("pin four low", 32'(pin_out[3]), 32'h0);
    pulses = 0;
    ins(io_latch_pkg::OP_A_SPECIAL, 5'h00, 1'b1, 8'h21);
    repeat (3) @(posedge clock_i);
    chk("special pins", 32'(pin_out[2:0]), 32'h6);
    chk("pin four pulse", 32'(pulses), 32'h1);
    scan_on <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      ins(io_latch_pkg::OP_SCAN_SETUP, 5'h00, 1'b0, scan_imm[i]);
      chk("scan select", 32'(seg_oe), 32'(scan_exp[i]));
      chk("halt source", 32'(halt_cycle), 32'(scan_imm[i][6]));
    end
    wr(io_latch_pkg::ADDR_INSTR, {3'h0, 5'h13, 16'h0000, 8'h10}, 4'h1);
    chk("torn instruction", {30'h0, resp}, {30'h0, io_latch_pkg::RESP_SLVERR});
    chk("scan kept", 32'(seg_oe), 32'h020);
    chk("drive level high", 32'(seg), 32'hfff);
    disp_high <= 1'b0;
    @(posedge clock_i);
    chk("drive level low", 32'(seg), 32'h000);
    scan_on <= 1'b0;
    @(posedge clock_i);
    chk("outside scan", 32'(seg_oe), 32'h000);
    summarize();
  end
endmodule
